// *** logic/osc_ctl_pkg.sv ***
`default_nettype none
package osc_ctl_pkg;

  // -----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // -----------------------------------------------------------------
  localparam logic [7:0] IDX_OSC_CTRL  = 8'hE2;
  localparam logic [7:0] IDX_COARSE    = 8'hE8;
  localparam logic [7:0] IDX_FINE      = 8'hFA;
  localparam logic [7:0] IDX_SYS_STAT  = 8'hFE;
  localparam logic [7:0] IDX_BANK      = 8'hF7;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int CTRL_FAST48_BIT  = 4;
  localparam int CTRL_EXTSEL_BIT  = 2;
  localparam int CTRL_DIS_BIT     = 1;
  localparam int STAT_REPEAT_BIT  = 7;
  localparam int STAT_RANGE_LSB   = 3;
  localparam int STAT_RAMRED_BIT  = 0;
  localparam int BANK_BIT         = 0;
  localparam int FINE_W           = 3;
  localparam int COARSE_W         = 8;
  localparam int TRIM_W           = COARSE_W + FINE_W;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0]        RST_COARSE = 8'h00;
  localparam logic [FINE_W-1:0] RST_FINE   = 3'h0;
  localparam logic [1:0]        RST_RANGE  = 2'h0;
  localparam logic              RST_BIT    = 1'b0;

  // -----------------------------------------------------------------
  // range codes and pin drive modes
  // -----------------------------------------------------------------
  localparam logic [1:0] RANGE_12MHZ = 2'h0;
  localparam logic [1:0] RANGE_6MHZ  = 2'h1;
  localparam logic [1:0] RANGE_24MHZ = 2'h2;
  localparam logic [1:0] RANGE_RSVD  = 2'h3;
  localparam logic [1:0] DM_PULLUP   = 2'h0;
  localparam logic [1:0] DM_STRONG   = 2'h1;
  localparam logic [1:0] DM_ANALOG   = 2'h2;
  localparam logic [1:0] DM_OPEN_LOW = 2'h3;

  // -----------------------------------------------------------------
  // oscillator model: phase accumulator
  // -----------------------------------------------------------------
  localparam int          ACC_W    = 16;
  localparam logic [15:0] BASE_INC = 16'h3C00;
  localparam logic [1:0]  SHIFT_24 = 2'h0;
  localparam logic [1:0]  SHIFT_12 = 2'h1;
  localparam logic [1:0]  SHIFT_6  = 2'h2;

  typedef struct packed {
    logic [1:0] drive_mode;
    logic       data;
  } pin_ctl_t;

  typedef struct packed {
    logic [1:0]        range;
    logic [TRIM_W-1:0] trim;
    logic              run;
    logic              ext_sel;
    logic              clk48_on;
  } osc_cfg_t;

  typedef enum logic [3:0] {
    SRC_OSC      = 4'h1,
    SRC_WAIT_EXT = 4'h2,
    SRC_EXT      = 4'h4,
    SRC_WAIT_OSC = 4'h8
  } src_state_t;

endpackage
`default_nettype wire

// *** logic/clock_source_switch.sv ***
`timescale 1ns/100ps
`default_nettype none
module clock_source_switch (
  // clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    ce,
  // sources
  input  wire logic                    osc_tick,
  input  wire logic                    osc_run,
  input  wire logic                    ext_tick,
  input  wire logic                    ext_sel,
  // system clock net
  output logic                         sys_tick,
  output osc_ctl_pkg::src_state_t      state
);
  import osc_ctl_pkg::*;

  src_state_t state_q;
  src_state_t state_d;

  // -----------------------------------------------------------------
  // glitch-free hand-over
  // -----------------------------------------------------------------
  // leave a source on its own edge, or at once if the oscillator is stopped; join the new one on its edge
  always_comb begin
    state_d  = state_q;
    sys_tick = 1'b0;
    case (state_q)
      SRC_OSC: begin
        sys_tick = osc_tick;
        if (ext_sel && (osc_tick || !osc_run)) begin
          state_d = SRC_WAIT_EXT;
        end
      end
      SRC_WAIT_EXT: begin
        sys_tick = ext_tick;
        if (!ext_sel) begin
          state_d = SRC_OSC;
        end else if (ext_tick) begin
          state_d = SRC_EXT;
        end
      end
      SRC_EXT: begin
        sys_tick = ext_tick;
        if (!ext_sel && ext_tick) begin
          state_d = SRC_WAIT_OSC;
        end
      end
      SRC_WAIT_OSC: begin
        sys_tick = osc_tick;
        if (ext_sel) begin
          state_d = SRC_EXT;
        end else if (osc_tick) begin
          state_d = SRC_OSC;
        end
      end
      default: begin
        state_d = SRC_OSC;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SRC_OSC;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign state = state_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ask_ext;
    ce && state_q == SRC_OSC && ext_sel && osc_tick;
  endsequence

  sequence s_on_ext_wait;
    state_q == SRC_WAIT_EXT && sys_tick == ext_tick;
  endsequence

  sequence s_ext_first;
    ce && state_q == SRC_WAIT_EXT && ext_sel && ext_tick;
  endsequence

  AST_OSC_DRIVES: assert property (state_q == SRC_OSC |-> sys_tick == osc_tick)
    else $error("oscillator state does not pass oscillator ticks");
  AST_EXT_DRIVES: assert property (state_q == SRC_EXT |-> sys_tick == ext_tick)
    else $error("external state does not pass external ticks");
  AST_NO_GLITCH: assert property (s_ask_ext |=> s_on_ext_wait)
    else $error("source hand-over produced a stray tick");
  AST_JOIN_EXT: assert property (s_ext_first |=> state_q == SRC_EXT)
    else $error("switch did not join the external clock");

endmodule
`default_nettype wire

// *** logic/osc_clock_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module osc_clock_control (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [9:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // boot and system status
  input  wire logic                  boot_start,
  input  wire logic                  trim_load,
  input  wire logic [7:0]            factory_trim,
  input  wire logic                  usb_lock_enable,
  input  wire logic                  on_chip_debug_mode,
  output logic                       ram_init_reduce,
  // external clock pin and its port control
  input  wire osc_ctl_pkg::pin_ctl_t pin_ctl,
  input  wire logic                  ext_clk_i,
  output logic                       ext_clk_o,
  output logic                       ext_clk_oe,
  // low-speed oscillator
  input  wire logic                  low_speed_osc,
  output logic                       low_speed_sync,
  // clock outputs
  output logic                       system_clock_net,
  output logic                       fast_48mhz_gate,
  output osc_ctl_pkg::osc_cfg_t      osc_cfg
);
  import osc_ctl_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [1:0] range_shift(input logic [1:0] r);
    case (r)
      RANGE_24MHZ: range_shift = SHIFT_24;
      RANGE_6MHZ:  range_shift = SHIFT_6;
      default:     range_shift = SHIFT_12;
    endcase
  endfunction

  function automatic logic [7:0] bitv(input logic b, input int pos);
    bitv = 8'h00;
    bitv[pos] = b;
  endfunction

  // -----------------------------------------------------------------
  // bus front end
  // -----------------------------------------------------------------
  logic              wr_q;
  logic [7:0]        idx_q;
  logic [31:0]       hrdata_q;
  logic              bank_q;
  logic              bank_d;
  logic              fast48_q;
  logic              fast48_d;
  logic              extsel_q;
  logic              extsel_d;
  logic              dis_q;
  logic              dis_d;
  logic [7:0]        coarse_q;
  logic [7:0]        coarse_d;
  logic [FINE_W-1:0] fine_q;
  logic [FINE_W-1:0] fine_d;
  logic [1:0]        range_q;
  logic [1:0]        range_d;
  logic              ramred_q;
  logic              ramred_d;
  logic              boot_seen_q;
  logic              repeat_q;

  wire       addr_ok  = hsel && htrans[1] && hready;
  wire [7:0] a_idx    = haddr[9:2];
  wire       bank1    = bank_q;
  wire [7:0] wdata    = hwdata[7:0];
  wire       wr_any   = wr_q && ce;
  wire       wr_ctrl  = wr_any && bank1 && idx_q == IDX_OSC_CTRL;
  wire       wr_crs   = wr_any && bank1 && idx_q == IDX_COARSE;
  wire       wr_fine  = wr_any && bank1 && idx_q == IDX_FINE && !usb_lock_enable;
  wire       wr_stat  = wr_any && idx_q == IDX_SYS_STAT;
  wire       wr_bank  = wr_any && idx_q == IDX_BANK;
  wire [1:0] wr_range = wdata[STAT_RANGE_LSB +: 2];

  assign bank_d   = wr_bank ? wdata[BANK_BIT] : bank_q;
  assign fast48_d = wr_ctrl ? wdata[CTRL_FAST48_BIT] : fast48_q;
  assign extsel_d = wr_ctrl ? wdata[CTRL_EXTSEL_BIT] : extsel_q;
  assign dis_d    = wr_ctrl ? wdata[CTRL_DIS_BIT] : dis_q;
  // boot trim load wins over a software write
  assign coarse_d = trim_load ? factory_trim :
                    wr_crs    ? wdata : coarse_q;
  assign fine_d   = wr_fine ? wdata[FINE_W-1:0] : fine_q;
  // reserved code leaves the running range alone
  assign range_d  = (wr_stat && wr_range != RANGE_RSVD) ? wr_range : range_q;
  assign ramred_d = wr_stat ? wdata[STAT_RAMRED_BIT] : ramred_q;

  // read mux from next values so a write followed by a read is coherent
  wire [7:0] rd_ctrl = bitv(fast48_d, CTRL_FAST48_BIT) | bitv(extsel_d, CTRL_EXTSEL_BIT)
                     | bitv(dis_d, CTRL_DIS_BIT);
  wire [7:0] rd_stat = bitv(repeat_q, STAT_REPEAT_BIT) | bitv(ramred_d, STAT_RAMRED_BIT)
                     | {3'h0, range_d, 3'h0};
  wire       a_bank1 = bank_d;
  wire [7:0] rd_byte = (a_idx == IDX_SYS_STAT)          ? rd_stat :
                       (a_idx == IDX_BANK)              ? bitv(bank_d, BANK_BIT) :
                       (a_bank1 && a_idx == IDX_OSC_CTRL) ? rd_ctrl :
                       (a_bank1 && a_idx == IDX_COARSE)   ? coarse_d :
                       (a_bank1 && a_idx == IDX_FINE)     ? {5'h00, fine_d} : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q     <= 1'b0;
      idx_q    <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else if (ce) begin
      wr_q     <= addr_ok && hwrite;
      idx_q    <= a_idx;
      hrdata_q <= (addr_ok && !hwrite) ? {24'h00_0000, rd_byte} : hrdata_q;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_q   <= RST_BIT;
      fast48_q <= RST_BIT;
      extsel_q <= RST_BIT;
      dis_q    <= RST_BIT;
      coarse_q <= RST_COARSE;
      fine_q   <= RST_FINE;
      range_q  <= RST_RANGE;
      ramred_q <= RST_BIT;
    end else if (ce) begin
      bank_q   <= bank_d;
      fast48_q <= fast48_d;
      extsel_q <= extsel_d;
      dis_q    <= dis_d;
      coarse_q <= coarse_d;
      fine_q   <= fine_d;
      range_q  <= range_d;
      ramred_q <= ramred_d;
    end
  end

  // second and later boot passes mark the status bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_seen_q <= 1'b0;
      repeat_q    <= 1'b0;
    end else if (ce && boot_start) begin
      boot_seen_q <= 1'b1;
      repeat_q    <= repeat_q || boot_seen_q;
    end
  end

  assign ram_init_reduce = ramred_q;

  // -----------------------------------------------------------------
  // oscillator model
  // -----------------------------------------------------------------
  logic [ACC_W-1:0] acc_q;
  logic             osc_tick_q;

  wire [TRIM_W-1:0] trim_word = {coarse_q, fine_q};
  wire [ACC_W-1:0]  inc_full  = BASE_INC + {{(ACC_W-TRIM_W){1'b0}}, trim_word};
  wire [ACC_W-1:0]  inc       = inc_full >> range_shift(range_q);
  wire [ACC_W:0]    acc_sum   = {1'b0, acc_q} + {1'b0, inc};
  wire              osc_run   = !dis_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q      <= '0;
      osc_tick_q <= 1'b0;
    end else if (ce) begin
      acc_q      <= osc_run ? acc_sum[ACC_W-1:0] : acc_q;
      osc_tick_q <= osc_run && acc_sum[ACC_W];
    end
  end

  // -----------------------------------------------------------------
  // external clock pin
  // -----------------------------------------------------------------
  wire in_en = pin_ctl.drive_mode != DM_ANALOG;
  assign ext_clk_o  = pin_ctl.drive_mode == DM_STRONG && pin_ctl.data;
  wire low_side = pin_ctl.drive_mode == DM_OPEN_LOW || pin_ctl.drive_mode == DM_PULLUP;
  assign ext_clk_oe = (pin_ctl.drive_mode == DM_STRONG) || (!pin_ctl.data && low_side);

  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic lso_s1_q;
  logic lso_s2_q;
  logic lso_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      lso_s1_q <= 1'b0;
      lso_s2_q <= 1'b0;
    end else if (ce) begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      lso_s1_q <= low_speed_osc;
      lso_s2_q <= lso_s1_q;
    end
  end

  // analog mode blocks the input after the synchroniser
  wire ext_tick = in_en && ext_s2_q && !ext_s3_q;

  // -----------------------------------------------------------------
  // source selection and clock outputs
  // -----------------------------------------------------------------
  logic       sys_tick;
  src_state_t src_state;

  clock_source_switch u_switch (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .osc_tick (osc_tick_q),
    .osc_run  (osc_run),
    .ext_tick (ext_tick),
    .ext_sel  (extsel_q),
    .sys_tick (sys_tick),
    .state    (src_state)
  );

  // low-speed input resampled on the active system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lso_q <= 1'b0;
    end else if (ce && sys_tick) begin
      lso_q <= lso_s2_q;
    end
  end

  assign low_speed_sync   = lso_q;
  assign system_clock_net = sys_tick;
  assign fast_48mhz_gate  = fast48_q || on_chip_debug_mode;
  assign osc_cfg = '{range: range_q, trim: trim_word, run: osc_run,
                     ext_sel: extsel_q, clk48_on: fast_48mhz_gate};

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr_stat_rsvd;
    wr_stat && wr_range == RANGE_RSVD;
  endsequence

  sequence s_wr_stat_ok;
    wr_stat && wr_range != RANGE_RSVD;
  endsequence

  sequence s_stat_bank0;
    wr_any && idx_q == IDX_SYS_STAT && !bank_q;
  endsequence

  sequence s_boot_again;
    ce && boot_start && boot_seen_q;
  endsequence

  sequence s_pin_digital_in;
    pin_ctl.drive_mode == DM_OPEN_LOW && pin_ctl.data;
  endsequence

  property p_stat_bank0;
    s_stat_bank0 |=> ramred_q == $past(wdata[STAT_RAMRED_BIT]);
  endproperty

  AST_RANGE_HOLD: assert property (s_wr_stat_rsvd |=> range_q == $past(range_q))
    else $error("reserved range code changed the range");
  AST_RANGE_NOW: assert property (s_wr_stat_ok |=> osc_cfg.range == $past(wr_range))
    else $error("range write did not take effect next cycle");
  AST_FINE_LOCK: assert property (usb_lock_enable |=> fine_q == $past(fine_q))
    else $error("fine trim changed under usb lock");
  AST_STAT_ANY_BANK: assert property (p_stat_bank0)
    else $error("status register not writable in bank zero");
  AST_FAST48: assert property (fast_48mhz_gate == (fast48_q || on_chip_debug_mode))
    else $error("48 MHz gate wrong");
  AST_DIS_STOP: assert property (ce && dis_q ##1 ce && dis_q |-> !osc_tick_q)
    else $error("oscillator ticks while disabled");
  AST_REPEAT: assert property (s_boot_again |=> repeat_q ##1 repeat_q)
    else $error("repeated boot not flagged");
  AST_BOOT_TRIM: assert property (ce && trim_load |=> coarse_q == $past(factory_trim))
    else $error("factory trim not loaded");
  AST_PIN_INPUT: assert property (s_pin_digital_in |-> !ext_clk_oe && in_en)
    else $error("open-drain high does not release the pin");

endmodule
`default_nettype wire

// *** dv/osc_clock_control_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module osc_clock_control_tb_top;
  import osc_ctl_pkg::*;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        hclk, hresetn, ce, hsel, hwrite, boot_start, trim_load;
  logic [9:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic [7:0]  factory_trim;
  logic        usb_lock_enable, on_chip_debug_mode, low_speed_osc;
  logic        hreadyout, hresp, ram_init_reduce, ext_clk_o, ext_clk_oe;
  logic        low_speed_sync, system_clock_net, fast_48mhz_gate;
  logic        ext_clk_i = 1'b0;
  logic        erun      = 1'b0;
  logic [3:0]  ediv      = 4'h0;
  pin_ctl_t    pin_ctl;
  osc_cfg_t    osc_cfg;
  int          err_total = 0;
  int          n_checks  = 0;
  int          pcnt      = 0;

  osc_clock_control dut_u (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .boot_start(boot_start), .trim_load(trim_load), .factory_trim(factory_trim),
    .usb_lock_enable(usb_lock_enable), .on_chip_debug_mode(on_chip_debug_mode),
    .ram_init_reduce(ram_init_reduce), .pin_ctl(pin_ctl), .ext_clk_i(ext_clk_i),
    .ext_clk_o(ext_clk_o), .ext_clk_oe(ext_clk_oe), .low_speed_osc(low_speed_osc),
    .low_speed_sync(low_speed_sync), .system_clock_net(system_clock_net),
    .fast_48mhz_gate(fast_48mhz_gate), .osc_cfg(osc_cfg)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // system tick counter and external pin clock, period 16 cycles
  always @(posedge hclk) begin
    if (system_clock_net === 1'b1) pcnt <= pcnt + 1;
    if (erun) ediv <= ediv + 4'h1;
    ext_clk_i <= ediv[3];
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic final_report;
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait for hready; a timeout ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      err_total++;
      final_report();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {idx, 2'b00};
    hwrite <= w;
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    chk(nm, rd, exp);
  endtask

  // ticks seen over cyc cycles must be e plus or minus one
  task automatic rate(input int cyc, input int e);
    int s;
    s = pcnt;
    repeat (cyc) @(posedge hclk);
    chk("tick rate", 32'((pcnt - s >= e - 1) && (pcnt - s <= e + 1)), 32'h1);
  endtask

  task automatic strobe(input logic tl);
    @(posedge hclk);
    if (tl) begin
      trim_load <= 1'b1;
    end else begin
      boot_start <= 1'b1;
    end
    @(posedge hclk);
    trim_load  <= 1'b0;
    boot_start <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk("cfg reset", 32'(osc_cfg), 32'h4);
    chk("ram reduce", 32'(ram_init_reduce), 32'h0);
    rdc("status", IDX_SYS_STAT, 32'h0);
    rdc("ctrl bank0", IDX_OSC_CTRL, 32'h0);
    rdc("unmapped", 8'h00, 32'h0);
    wr(IDX_BANK, 32'h1);
    rdc("ctrl", IDX_OSC_CTRL, 32'h0);
    rdc("coarse", IDX_COARSE, 32'h0);
    rdc("fine", IDX_FINE, 32'h0);
  endtask

  task automatic t_status;
    wr(IDX_SYS_STAT, 32'h99);
    rdc("status rsvd", IDX_SYS_STAT, 32'h01);
    chk("ram reduce", 32'(ram_init_reduce), 32'h1);
    wr(IDX_BANK, 32'h0);
    rdc("status bank0", IDX_SYS_STAT, 32'h01);
    wr(IDX_OSC_CTRL, 32'h10);
    wr(IDX_SYS_STAT, 32'h10);
    @(posedge hclk);
    chk("range now", 32'(osc_cfg.range), 32'(RANGE_24MHZ));
    wr(IDX_SYS_STAT, 32'h18);
    @(posedge hclk);
    chk("range kept", 32'(osc_cfg.range), 32'(RANGE_24MHZ));
    chk("ram reduce", 32'(ram_init_reduce), 32'h0);
    wr(IDX_BANK, 32'h1);
    rdc("ctrl ignored", IDX_OSC_CTRL, 32'h0);
  endtask

  task automatic t_rates;
    logic [1:0] code [3] = '{RANGE_24MHZ, RANGE_12MHZ, RANGE_6MHZ};
    int         e [3]    = '{60, 30, 15};
    for (int i = 0; i < 3; i++) begin
      wr(IDX_SYS_STAT, {27'h0, code[i], 3'h0});
      rate(256, e[i]);
    end
    wr(IDX_COARSE, 32'hFF);
    wr(IDX_FINE, 32'h7);
    wr(IDX_SYS_STAT, 32'h10);
    rate(256, 68);
  endtask

  task automatic t_boot;
    strobe(1'b0);
    rdc("one boot", IDX_SYS_STAT, 32'h10);
    strobe(1'b0);
    wr(IDX_SYS_STAT, 32'h10);
    rdc("repeat boot", IDX_SYS_STAT, 32'h90);
  endtask

  task automatic t_trim;
    factory_trim <= 8'hA5;
    wr(IDX_SYS_STAT, 32'h08);
    strobe(1'b1);
    rdc("coarse load", IDX_COARSE, 32'hA5);
    wr(IDX_FINE, 32'h5);
    rdc("fine", IDX_FINE, 32'h5);
    chk("trim word", 32'(osc_cfg.trim), 32'h52D);
    usb_lock_enable <= 1'b1;
    wr(IDX_FINE, 32'h2);
    rdc("fine locked", IDX_FINE, 32'h5);
    usb_lock_enable <= 1'b0;
    wr(IDX_COARSE, 32'h3C);
    rdc("coarse", IDX_COARSE, 32'h3C);
    wr(IDX_SYS_STAT, 32'h10);
  endtask

  task automatic t_ctrl;
    wr(IDX_OSC_CTRL, 32'h10);
    @(posedge hclk);
    chk("gate on", 32'(fast_48mhz_gate), 32'h1);
    wr(IDX_OSC_CTRL, 32'h00);
    @(posedge hclk);
    chk("gate off", 32'(fast_48mhz_gate), 32'h0);
    on_chip_debug_mode <= 1'b1;
    @(posedge hclk);
    chk("gate debug", 32'(fast_48mhz_gate), 32'h1);
    chk("cfg gate", 32'(osc_cfg.clk48_on), 32'h1);
    on_chip_debug_mode <= 1'b0;
    wr(IDX_OSC_CTRL, 32'h02);
    @(posedge hclk);
    chk("run", 32'(osc_cfg.run), 32'h0);
    rate(64, 0);
    rdc("ctrl", IDX_OSC_CTRL, 32'h02);
    wr(IDX_OSC_CTRL, 32'h00);
  endtask

  task automatic t_pin;
    logic e_oe;
    for (int m = 0; m < 8; m++) begin
      pin_ctl <= '{drive_mode: m[2:1], data: m[0]};
      @(posedge hclk);
      e_oe = (m[2:1] == DM_STRONG) || ((m[2:1] != DM_ANALOG) && !m[0]);
      chk("pin oe", 32'(ext_clk_oe), 32'(e_oe));
      chk("pin out", 32'(e_oe ? ext_clk_o : 1'b0), 32'(e_oe & m[0]));
    end
  endtask

  task automatic t_ext;
    pin_ctl <= '{drive_mode: DM_ANALOG, data: 1'b1};
    erun <= 1'b1;
    wr(IDX_OSC_CTRL, 32'h04);
    @(posedge hclk);
    chk("ext sel", 32'(osc_cfg.ext_sel), 32'h1);
    rate(160, 0);
    pin_ctl <= '{drive_mode: DM_OPEN_LOW, data: 1'b1};
    repeat (64) @(posedge hclk);
    rate(320, 20);
    low_speed_osc <= 1'b1;
    repeat (80) @(posedge hclk);
    chk("slow sync", 32'(low_speed_sync), 32'h1);
    wr(IDX_OSC_CTRL, 32'h00);
    repeat (64) @(posedge hclk);
    erun <= 1'b0;
    rate(256, 62);
    low_speed_osc <= 1'b0;
    repeat (80) @(posedge hclk);
    chk("slow sync", 32'(low_speed_sync), 32'h0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    hresetn            = 1'b0;
    ce                 = 1'b1;
    hsel               = 1'b0;
    haddr              = 10'h000;
    htrans             = 2'h0;
    hwrite             = 1'b0;
    hsize              = 3'h2;
    hwdata             = 32'h0000_0000;
    boot_start         = 1'b0;
    trim_load          = 1'b0;
    factory_trim       = 8'h00;
    usb_lock_enable    = 1'b0;
    on_chip_debug_mode = 1'b0;
    low_speed_osc      = 1'b0;
    pin_ctl            = '{drive_mode: DM_OPEN_LOW, data: 1'b1};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_status();
    t_rates();
    t_boot();
    t_trim();
    t_ctrl();
    t_pin();
    t_ext();
    final_report();
  end
endmodule
`default_nettype wire
